// ==== hdl/scl_defs.svh ====
// offsets, field positions, reset values and timing of the config loader
`ifndef SCL_DEFS_SVH
`define SCL_DEFS_SVH
`define SCL_OFS_SUBVEN  8'h00
`define SCL_OFS_SUBID   8'h04
`define SCL_OFS_ROMBAR  8'h08
`define SCL_OFS_STATUS  8'h0c
`define SCL_OFS_PINCTL  8'h10
`define SCL_PIN0_BIT    0
`define SCL_PIN1_BIT    1
`define SCL_FLASH_BIT   4
`define SCL_MODE_A      2'b11
`define SCL_MODE_B      2'b10
`define SCL_MODE_C      2'b00
`define SCL_MODE_D      2'b01
`define SCL_BASE_A      8'h00
`define SCL_BASE_C      8'hfb
`define SCL_SEED        8'h55
`define SCL_DEV_WR      8'ha0
`define SCL_DEV_RD      8'ha1
`define SCL_LAST_RX     3'h4
`define SCL_ROM_MIN     32'h0000_4000
`define SCL_ROM_NONE    3'h7
`define SCL_SLOW_EXTRA  2'h2
`define SCL_SUB_RST     16'h0000
`define SCL_BAR_RST     32'h0000_0000
`define SCL_PINCTL_RST  3'h0
`define SCL_CLK_NS      8
`define SCL_LINK_NS     80
`define SCL_SETTLE_NS   64
`define SCL_QUARTER_NS  1280
`endif

// ==== hdl/scl_pkg.sv ====
// state types of the config loader
package scl_pkg;
  typedef enum logic [3:0] {
    CS_SETTLE = 4'b0001,
    CS_LOAD   = 4'b0010,
    CS_CHECK  = 4'b0100,
    CS_READY  = 4'b1000
  } scl_ctl_e;
  typedef enum logic [7:0] {
    TS_IDLE  = 8'h01,
    TS_START = 8'h02,
    TS_TXBIT = 8'h04,
    TS_TXACK = 8'h08,
    TS_RXBIT = 8'h10,
    TS_RXACK = 8'h20,
    TS_STOP  = 8'h40,
    TS_DONE  = 8'h80
  } scl_twi_e;
endpackage : scl_pkg

// ==== hdl/scl_load_if.sv ====
// link between load control and the two-wire reader
interface scl_load_if;
  logic        req;
  logic [7:0]  baseAddr;
  logic        sdaRaw;
  logic        done;
  logic        absent;
  logic [39:0] data;
  logic        sdaLow;
  logic        sclLow;
  modport ctrl (output req, baseAddr, sdaRaw,
                input done, absent, data, sdaLow, sclLow);
  modport engine (input req, baseAddr, sdaRaw,
                  output done, absent, data, sdaLow, sclLow);
endinterface : scl_load_if

// ==== hdl/scl_twi_reader.sv ====
// two-wire eeprom reader on the link clock
`include "scl_defs.svh"
module scl_twi_reader (
  input wire logic   linkClock,
  input wire logic   rst_n,
  scl_load_if.engine ld
);
  localparam int QUARTER = `SCL_QUARTER_NS / `SCL_LINK_NS;
  logic             lrMeta_q;
  logic             lrN_q;
  logic             reqMeta_q;
  logic             req_q;
  logic             sdaMeta_q;
  logic             sda_q;
  scl_pkg::scl_twi_e st_q;
  logic [4:0]       qCnt_q;
  logic [1:0]       ph_q;
  logic [7:0]       sh_q;
  logic [2:0]       bit_q;
  logic [2:0]       rxIdx_q;
  logic [1:0]       txIdx_q;
  default clocking cb @(posedge linkClock); endclocking
  default disable iff (!lrN_q);

  always_ff @(posedge linkClock or negedge rst_n) begin
    if (!rst_n) begin
      lrMeta_q <= 1'b0;
      lrN_q    <= 1'b0;
    end else begin
      lrMeta_q <= 1'b1;
      lrN_q    <= lrMeta_q;
    end
  end
  always_ff @(posedge linkClock or negedge lrN_q) begin
    if (!lrN_q) begin
      {reqMeta_q, req_q, sdaMeta_q, sda_q} <= 4'h0;
    end else begin
      {reqMeta_q, req_q} <= {ld.req, reqMeta_q};
      {sdaMeta_q, sda_q} <= {ld.sdaRaw, sdaMeta_q};
    end
  end

  wire       active  = !(st_q inside {scl_pkg::TS_IDLE, scl_pkg::TS_DONE});
  wire       tick    = qCnt_q == 5'(QUARTER - 1);
  wire       stepEnd = tick && ph_q == 2'h3;
  wire       sample  = tick && ph_q == 2'h2;
  wire [7:0] txByte  = txIdx_q == 2'h0 ? `SCL_DEV_WR :
                       txIdx_q == 2'h1 ? ld.baseAddr : `SCL_DEV_RD;
  wire       sclLowD = st_q == scl_pkg::TS_STOP ? ph_q == 2'h0 :
                       active && (ph_q == 2'h0 || ph_q == 2'h3);
  wire       sdaLowD = st_q == scl_pkg::TS_START ? ph_q[1] :
                       st_q == scl_pkg::TS_STOP  ? !ph_q[1] :
                       st_q == scl_pkg::TS_TXBIT ? !sh_q[7] :
                       st_q == scl_pkg::TS_RXACK &&
                       rxIdx_q != `SCL_LAST_RX;

  always_ff @(posedge linkClock or negedge lrN_q) begin
    if (!lrN_q) begin
      qCnt_q    <= 5'h0;
      ph_q      <= 2'h0;
      ld.sdaLow <= 1'b0;
      ld.sclLow <= 1'b0;
    end else begin
      qCnt_q    <= (!active || tick) ? 5'h0 : qCnt_q + 5'h1;
      ph_q      <= !active ? 2'h0 : ph_q + {1'b0, tick};
      ld.sdaLow <= sdaLowD;
      ld.sclLow <= sclLowD;
    end
  end

  // random-address write, repeated start, sequential read of five bytes
  always_ff @(posedge linkClock or negedge lrN_q) begin
    if (!lrN_q) begin
      st_q      <= scl_pkg::TS_IDLE;
      {sh_q, bit_q, rxIdx_q, txIdx_q} <= 16'h0;
      ld.done   <= 1'b0;
      ld.absent <= 1'b0;
      ld.data   <= 40'h0;
    end else begin
      if (sample && st_q == scl_pkg::TS_RXBIT) sh_q <= {sh_q[6:0], sda_q};
      if (sample && st_q == scl_pkg::TS_TXACK && sda_q) begin
        ld.absent <= 1'b1;
      end
      unique case (st_q)
        scl_pkg::TS_IDLE: if (req_q) st_q <= scl_pkg::TS_START;
        scl_pkg::TS_START: if (stepEnd) begin
          st_q  <= scl_pkg::TS_TXBIT;
          sh_q  <= txByte;
          bit_q <= 3'h7;
        end
        scl_pkg::TS_TXBIT: if (stepEnd) begin
          if (bit_q == 3'h0) st_q <= scl_pkg::TS_TXACK;
          bit_q <= bit_q - 3'h1;
          sh_q  <= {sh_q[6:0], 1'b0};
        end
        scl_pkg::TS_TXACK: if (stepEnd) begin
          txIdx_q <= txIdx_q + 2'h1;
          bit_q   <= 3'h7;
          sh_q    <= txIdx_q == 2'h0 ? ld.baseAddr : sh_q;
          if (ld.absent) st_q <= scl_pkg::TS_STOP;
          else if (txIdx_q == 2'h0) st_q <= scl_pkg::TS_TXBIT;
          else if (txIdx_q == 2'h1) st_q <= scl_pkg::TS_START;
          else st_q <= scl_pkg::TS_RXBIT;
        end
        scl_pkg::TS_RXBIT: if (stepEnd) begin
          if (bit_q == 3'h0) st_q <= scl_pkg::TS_RXACK;
          bit_q <= bit_q - 3'h1;
        end
        scl_pkg::TS_RXACK: if (stepEnd) begin
          ld.data[rxIdx_q*8 +: 8] <= sh_q;
          rxIdx_q <= rxIdx_q + 3'h1;
          bit_q   <= 3'h7;
          st_q    <= rxIdx_q == `SCL_LAST_RX ? scl_pkg::TS_STOP
                                             : scl_pkg::TS_RXBIT;
        end
        scl_pkg::TS_STOP: if (stepEnd) st_q <= scl_pkg::TS_DONE;
        scl_pkg::TS_DONE: ld.done <= 1'b1;
      endcase
    end
  end

  a_five_bytes: assert property (
    $rose(ld.done) && !ld.absent |-> rxIdx_q == 3'h5)
    else $error("read did not end after five bytes");
  a_nack_stops: assert property (
    st_q == scl_pkg::TS_TXACK && stepEnd && ld.absent
    |=> st_q == scl_pkg::TS_STOP)
    else $error("missing acknowledge did not end the read");
endmodule : scl_twi_reader

// ==== hdl/scl_config_loader.sv ====
// strap sampling, eeprom autoload and config registers on wishbone
//
// Behaviour
// - both eeprom mode straps are sampled after every reset and pick one of four modes.
// - with both mode straps high, pin zero carries data and pin one the clock.
// - with both mode straps high, exactly the five bytes at 00h to 04h are read.
// - bytes 0 and 1 form the vendor id low and high, bytes 2 and 3 the subsystem id.
// - the fifth byte must make seed 55h plus all five bytes sum to zero, and is checked.
// - an absent eeprom or a bad checksum leaves both id registers reading zero.
// - with low strap down and high strap up, both pins follow software only.
// - in the software mode nothing is loaded and the id registers are writable, reset zero.
// - the three rom size straps give 16 KB doubling per code up to 1024 KB, 111 is none.
// - shortly after reset release the memory straps are sensed and configure rom logic.
// - a low slow rom strap adds two clock cycles to each rom data access.
// - the rom base register shows the strapped size through standard bar sizing.
// - the flash programming supply pin follows a software control bit.
// - with both mode straps low, pin one is data, pin zero clock, bytes FBh to FFh load.
`include "scl_defs.svh"
module scl_config_loader (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        linkClock,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic [7:0]  localMemoryBus,
  input  wire logic        generalPinZeroIn,
  output logic             generalPinZeroOut,
  output logic             generalPinZeroOe,
  input  wire logic        generalPinOneIn,
  output logic             generalPinOneOut,
  output logic             generalPinOneOe,
  output logic             flashSupplyEnablePin,
  output logic      [1:0]  romExtraCycles
);
  localparam int SETTLE =
    (`SCL_SETTLE_NS + `SCL_CLK_NS - 1) / `SCL_CLK_NS;

  scl_load_if ld ();

  scl_pkg::scl_ctl_e ctl_q;
  logic [3:0]       settle_q;
  logic [12:0]      syncMeta_q;
  logic [12:0]      sync_q;
  logic [1:0]       eepromMode_q;
  logic [2:0]       romCode_q;
  logic             slowRom_q;
  logic [1:0]       romExtra_q;
  logic [15:0]      subVen_q;
  logic [15:0]      subId_q;
  logic [31:0]      romBar_q;
  logic [2:0]       pinCtl_q;
  logic             loadOk_q;
  logic             absent_q;
  logic             req_q;
  logic [7:0]       base_q;
  logic             ack_q;
  logic [31:0]      rdData_q;
  logic             pin0Oe_q;
  logic             pin1Oe_q;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  function automatic logic [31:0] mergeWord(input logic [31:0] old,
                                            input logic [31:0] nw,
                                            input logic [3:0]  sel);
    mergeWord = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) mergeWord[i*8 +: 8] = nw[i*8 +: 8];
    end
  endfunction : mergeWord

  // bar bits that software may write; the rest read zero
  function automatic logic [31:0] romMask(input logic [2:0] code);
    romMask = (code == `SCL_ROM_NONE) ? 32'h0 :
              (~((`SCL_ROM_MIN << code) - 32'h1) | 32'h1);
  endfunction : romMask

  function automatic logic sumOk(input logic [39:0] b);
    logic [7:0] s;
    s = `SCL_SEED + b[7:0] + b[15:8] + b[23:16] + b[31:24] + b[39:32];
    sumOk = s == 8'h00;
  endfunction : sumOk

  scl_twi_reader u_reader (
    .linkClock (linkClock),
    .rst_n     (rst_n),
    .ld        (ld.engine)
  );

  // synchronisers for pins, straps and the reader's levels
  wire       doneS    = sync_q[2];
  wire       sdaLowS  = sync_q[0];
  wire       sclLowS  = sync_q[1];
  wire       pin0S    = sync_q[3];
  wire       pin1S    = sync_q[4];
  wire [7:0] strapS   = sync_q[12:5];

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      syncMeta_q <= 13'h0;
      sync_q     <= 13'h0;
    end else begin
      syncMeta_q <= {localMemoryBus, generalPinOneIn, generalPinZeroIn,
                     ld.done, ld.sclLow, ld.sdaLow};
      sync_q     <= syncMeta_q;
    end
  end

  wire modeA     = eepromMode_q == `SCL_MODE_A;
  wire modeB     = eepromMode_q == `SCL_MODE_B;
  wire modeC     = eepromMode_q == `SCL_MODE_C;
  wire autoMode  = modeA || modeC;
  wire settleEnd = ctl_q == scl_pkg::CS_SETTLE &&
                   settle_q == 4'(SETTLE - 1);
  wire [1:0] strapMode = strapS[7:6];
  wire strapAuto = strapMode == `SCL_MODE_A || strapMode == `SCL_MODE_C;
  wire csGood    = !ld.absent && sumOk(ld.data);

  assign ld.req      = req_q;
  assign ld.baseAddr = base_q;
  assign ld.sdaRaw   = modeA ? generalPinZeroIn : generalPinOneIn;

  // load sequence: settle, sense straps, autoload, check
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctl_q    <= scl_pkg::CS_SETTLE;
      settle_q <= 4'h0;
      req_q    <= 1'b0;
      base_q   <= `SCL_BASE_A;
      loadOk_q <= 1'b0;
      absent_q <= 1'b0;
    end else begin
      unique case (ctl_q)
        scl_pkg::CS_SETTLE: begin
          settle_q <= settle_q + 4'h1;
          if (settleEnd) begin
            ctl_q  <= strapAuto ? scl_pkg::CS_LOAD
                                : scl_pkg::CS_READY;
            req_q  <= strapAuto;
            base_q <= strapMode == `SCL_MODE_A ? `SCL_BASE_A
                                               : `SCL_BASE_C;
          end
        end
        scl_pkg::CS_LOAD: if (doneS) ctl_q <= scl_pkg::CS_CHECK;
        scl_pkg::CS_CHECK: begin
          ctl_q    <= scl_pkg::CS_READY;
          loadOk_q <= csGood;
          absent_q <= ld.absent;
        end
        scl_pkg::CS_READY: ctl_q <= scl_pkg::CS_READY;
      endcase
    end
  end

  // strap capture, taken once the settle time has run out
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      eepromMode_q <= `SCL_MODE_D;
      romCode_q    <= `SCL_ROM_NONE;
      slowRom_q    <= 1'b0;
      romExtra_q   <= 2'h0;
    end else if (settleEnd) begin
      eepromMode_q <= strapMode;
      romCode_q    <= strapS[3:1];
      slowRom_q    <= !strapS[0];
      romExtra_q   <= strapS[0] ? 2'h0 : `SCL_SLOW_EXTRA;
    end
  end

  // wishbone classic slave: ack one cycle after the strobe
  wire       busReq = wb_cyc_i && wb_stb_i && !ack_q;
  wire       busWr  = busReq && wb_we_i;
  wire       selVen = wb_adr_i == `SCL_OFS_SUBVEN;
  wire       selId  = wb_adr_i == `SCL_OFS_SUBID;
  wire       selBar = wb_adr_i == `SCL_OFS_ROMBAR;
  wire       selSt  = wb_adr_i == `SCL_OFS_STATUS;
  wire       selPin = wb_adr_i == `SCL_OFS_PINCTL;
  wire [31:0] barRd  = romBar_q & romMask(romCode_q);
  wire [31:0] statRd = {20'h0, romExtra_q, loadOk_q, absent_q,
                        ctl_q == scl_pkg::CS_READY, eepromMode_q,
                        slowRom_q, 1'b0, romCode_q};
  wire [31:0] pinRd  = {22'h0, pin1S, pin0S, 3'h0, pinCtl_q[2], 2'h0,
                        pinCtl_q[1:0]};
  wire [31:0] rdMux  = selVen ? {16'h0, subVen_q} :
                       selId  ? {16'h0, subId_q}  :
                       selBar ? barRd :
                       selSt  ? statRd :
                       selPin ? pinRd : 32'h0;
  wire [31:0] venWr  = mergeWord({16'h0, subVen_q}, wb_dat_i, wb_sel_i);
  wire [31:0] idWr   = mergeWord({16'h0, subId_q}, wb_dat_i, wb_sel_i);
  wire [31:0] barWr  = mergeWord(romBar_q, wb_dat_i, wb_sel_i);
  wire [31:0] pinWr  = mergeWord(pinRd, wb_dat_i, wb_sel_i);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ack_q    <= 1'b0;
      rdData_q <= 32'h0;
    end else begin
      ack_q    <= busReq;
      rdData_q <= busReq ? rdMux : 32'h0;
    end
  end

  // id registers: zero until a good load, writable only in software mode
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      subVen_q <= `SCL_SUB_RST;
      subId_q  <= `SCL_SUB_RST;
    end else if (ctl_q == scl_pkg::CS_CHECK && csGood) begin
      subVen_q <= ld.data[15:0];
      subId_q  <= ld.data[31:16];
    end else if (busWr && modeB && ctl_q == scl_pkg::CS_READY) begin
      if (selVen) subVen_q <= venWr[15:0];
      if (selId) subId_q <= idWr[15:0];
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      romBar_q <= `SCL_BAR_RST;
      pinCtl_q <= `SCL_PINCTL_RST;
    end else if (busWr) begin
      if (selBar) romBar_q <= barWr & romMask(romCode_q);
      if (selPin) pinCtl_q <= {pinWr[`SCL_FLASH_BIT],
                               pinWr[`SCL_PIN1_BIT],
                               pinWr[`SCL_PIN0_BIT]};
    end
  end

  // open-drain pins: autoload owns them while loading, software in mode b
  wire pin0OeD = ctl_q == scl_pkg::CS_LOAD ?
                   (modeA ? sdaLowS : sclLowS) :
                 modeB && pinCtl_q[0];
  wire pin1OeD = ctl_q == scl_pkg::CS_LOAD ?
                   (modeA ? sclLowS : sdaLowS) :
                 modeB && pinCtl_q[1];

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pin0Oe_q <= 1'b0;
      pin1Oe_q <= 1'b0;
    end else begin
      pin0Oe_q <= pin0OeD;
      pin1Oe_q <= pin1OeD;
    end
  end

  assign wb_ack_o             = ack_q;
  assign wb_dat_o             = rdData_q;
  assign generalPinZeroOe     = pin0Oe_q;
  assign generalPinOneOe      = pin1Oe_q;
  assign generalPinZeroOut    = 1'b0;
  assign generalPinOneOut     = 1'b0;
  assign flashSupplyEnablePin = pinCtl_q[2];
  assign romExtraCycles       = romExtra_q;

  sequence s_busReq;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_ackPulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence

  a_bus_ack_pulse: assert property (s_busReq |=> s_ackPulse)
    else $error("wishbone ack not a single cycle after request");
  a_strap_mode: assert property (
    settleEnd |=> eepromMode_q == $past(strapS[7:6]))
    else $error("mode strap not captured at settle end");
  a_mode_a_pins: assert property (
    ctl_q == scl_pkg::CS_LOAD && modeA ##1 ctl_q == scl_pkg::CS_LOAD
    |-> generalPinZeroOe == $past(sdaLowS) &&
        generalPinOneOe == $past(sclLowS))
    else $error("mode a pin roles wrong");
  a_mode_c_pins: assert property (
    ctl_q == scl_pkg::CS_LOAD && modeC ##1 ctl_q == scl_pkg::CS_LOAD
    |-> generalPinOneOe == $past(sdaLowS) &&
        generalPinZeroOe == $past(sclLowS))
    else $error("mode c pin roles wrong");
  a_sum_check: assert property (
    ctl_q == scl_pkg::CS_CHECK && !ld.absent &&
    8'(`SCL_SEED + ld.data[7:0] + ld.data[15:8] + ld.data[23:16] +
       ld.data[31:24] + ld.data[39:32]) != 8'h00
    |=> !loadOk_q && subVen_q == 16'h0 && subId_q == 16'h0)
    else $error("bad checksum accepted");
  a_zero_before_ok: assert property (
    autoMode && !loadOk_q |-> subVen_q == 16'h0 && subId_q == 16'h0)
    else $error("id registers changed without a good load");
  a_sw_no_load: assert property (
    modeB |-> !req_q && ctl_q != scl_pkg::CS_LOAD)
    else $error("load started in software mode");
  a_slow_rom: assert property (
    settleEnd && !strapS[0] |=> romExtraCycles == 2'h2 ##1
    romExtraCycles == 2'h2)
    else $error("slow rom did not add two cycles");
  a_no_rom_bar: assert property (
    romCode_q == 3'h7 |-> barRd == 32'h0)
    else $error("bar answers with no memory strapped");
  a_flash_follow: assert property (
    busWr && selPin && wb_sel_i[0]
    |=> flashSupplyEnablePin == $past(wb_dat_i[4]))
    else $error("flash supply pin does not follow its bit");

  // load outcome, pin ownership and strap capture
  a_mode_a_base: assert property (
    settleEnd && strapMode == `SCL_MODE_A |=> base_q == `SCL_BASE_A)
    else $error("mode a load does not start at byte 00h");
  a_mode_c_base: assert property (
    settleEnd && strapMode == `SCL_MODE_C |=> base_q == `SCL_BASE_C)
    else $error("mode c load does not start at byte fbh");
  a_good_load: assert property (
    ctl_q == scl_pkg::CS_CHECK && csGood
    |=> loadOk_q && subVen_q == $past(ld.data[15:0]) &&
        subId_q == $past(ld.data[31:16]))
    else $error("good load did not reach the id registers");
  a_absent_zero: assert property (
    ctl_q == scl_pkg::CS_CHECK && ld.absent
    |=> absent_q && subVen_q == 16'h0 && subId_q == 16'h0)
    else $error("absent eeprom left nonzero ids");
  a_sw_pins: assert property (
    modeB |=> generalPinZeroOe == $past(pinCtl_q[0]) &&
              generalPinOneOe == $past(pinCtl_q[1]))
    else $error("software pin control not followed");
  a_pins_released: assert property (
    autoMode && ctl_q == scl_pkg::CS_READY
    |=> !generalPinZeroOe && !generalPinOneOe)
    else $error("pins still pulled after the load");
  a_strap_rom: assert property (
    settleEnd |=> romCode_q == $past(strapS[3:1]) &&
    romExtraCycles == ($past(strapS[0]) ? 2'h0 : `SCL_SLOW_EXTRA))
    else $error("rom straps not captured at settle end");
  a_sw_id_write: assert property (
    busWr && selId && modeB && ctl_q == scl_pkg::CS_READY &&
    wb_sel_i[1:0] == 2'h3 |=> subId_q == $past(wb_dat_i[15:0]))
    else $error("software mode id write lost");
  a_id_locked: assert property (
    busWr && !modeB && ctl_q == scl_pkg::CS_READY
    |=> $stable(subVen_q) && $stable(subId_q))
    else $error("id registers written outside software mode");
endmodule : scl_config_loader

// ==== test/scl_eeprom_model.sv ====
// behavioural two-wire eeprom answering the autoload
module scl_eeprom_model (
  input  wire logic scl,
  input  wire logic sda,
  input  wire logic present,
  output logic      sdaLow
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [256];
  logic [7:0] sh = 8'h00;
  logic [7:0] ptr = 8'h00;
  int         ph = 0;
  int         cnt = 0;
  logic       acked = 1'b0;
  initial sdaLow = 1'b0;
  always @(negedge sda) begin
    if (scl === 1'b1) begin // start or repeated start
      ph = 1;
      cnt = 0;
    end
  end
  always @(posedge sda) begin
    if (scl === 1'b1) begin
      ph = 0;
    end
  end
  always @(posedge scl) begin
    if (ph != 0 && cnt < 8) begin
      sh = {sh[6:0], sda};
      cnt++;
    end else if (ph != 0) begin
      cnt = 0;
      if (ph == 3 && sda) ph = 0; // master nack ends the read
      else if (ph == 3) ptr++; // sequential read
      else if (!acked) ph = 0;
      else if (ph == 1) ph = sh[0] ? 3 : 2;
      else ph = 0;
    end
  end
  always @(negedge scl) begin
    acked = present && ((ph == 1 && sh[7:1] == 7'h50) || ph == 2);
    if (ph == 2 && cnt == 8) ptr = sh; // random address set
    if (cnt == 8) sdaLow = acked && ph != 3;
    else sdaLow = ph == 3 && !mem[ptr][7 - cnt]; // msb first
  end
endmodule : scl_eeprom_model

// ==== test/tb_top.sv ====
// self-checking bench of the strap and eeprom config loader
`include "scl_defs.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock = 1'b0;
  logic        linkClock = 1'b0;
  logic        rst_n = 1'b0;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic [7:0]  localMemoryBus = 8'h00;
  logic        pin0Oe;
  logic        pin1Oe;
  logic        pin0Out;
  logic        pin1Out;
  logic        flashPin;
  logic [1:0]  romExtraCycles;
  logic        eepLow;
  logic        present = 1'b0;
  logic [31:0] rd;
  logic [15:0] wr;
  int          fails = 0;
  int          num_checks = 0;
  int          cycles = 0;
  int          code;
  int          sum;
  wire         sdaOnZero = localMemoryBus[7:6] == 2'b11;
  wire         pin0 = ~(pin0Oe | (eepLow & sdaOnZero));
  wire         pin1 = ~(pin1Oe | (eepLow & ~sdaOnZero));
  always #4 clock = ~clock;
  initial #13 forever #40 linkClock = ~linkClock;
  scl_config_loader uut (
    .clock(clock), .rst_n(rst_n), .linkClock(linkClock),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .localMemoryBus(localMemoryBus),
    .generalPinZeroIn(pin0), .generalPinZeroOut(pin0Out),
    .generalPinZeroOe(pin0Oe),
    .generalPinOneIn(pin1), .generalPinOneOut(pin1Out),
    .generalPinOneOe(pin1Oe),
    .flashSupplyEnablePin(flashPin), .romExtraCycles(romExtraCycles));
  scl_eeprom_model eep (
    .scl(sdaOnZero ? pin1 : pin0), .sda(sdaOnZero ? pin0 : pin1),
    .present(present), .sdaLow(eepLow));
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : tally_and_finish
  always @(posedge clock) begin
    cycles++;
    if (cycles == 80000) begin
      fails++;
      $display("BAD %0t timeout", $time);
      tally_and_finish();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    num_checks++;
    if (got !== want) begin
      fails++;
      $display("BAD %0t got %h want %h", $time, got, want);
    end
  endtask : chk
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clock);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 40);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
    @(posedge clock);
    if (n >= 40) chk(32'h0, 32'h1);
  endtask : wb
  task automatic boot(input logic [1:0] mode, input logic on, input int c);
    code = c;
    present = on;
    rst_n <= 1'b0;
    localMemoryBus <= {mode, 2'b00, 3'(c), 1'($urandom)};
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    repeat (12) @(posedge clock);
  endtask : boot
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      wb(1'b0, `SCL_OFS_STATUS, 32'h0);
      n++;
    end while (rd[7] !== 1'b1 && n < 40000);
    chk(32'(rd[7]), 32'h1);
  endtask : wait_ready
  task automatic rom_checks();
    logic [31:0] m;
    m = code == 7 ? 32'h0 : (32'h0 - (`SCL_ROM_MIN << code)) | 32'h1;
    wb(1'b1, `SCL_OFS_ROMBAR, 32'hffff_ffff);
    wb(1'b0, `SCL_OFS_ROMBAR, 32'h0);
    chk(rd, m);
    wb(1'b0, `SCL_OFS_STATUS, 32'h0);
    chk({29'h0, rd[2:0]}, 32'(code));
    chk({30'h0, romExtraCycles}, localMemoryBus[0] ? 32'h0 : 32'h2);
  endtask : rom_checks
  initial begin
    void'($urandom(32'h9702));
    sum = 32'h55;
    for (int i = 0; i < 4; i++) begin
      eep.mem[i] = 8'($urandom);
      sum += eep.mem[i];
    end
    eep.mem[4] = 8'(-sum);
    boot(2'b11, 1'b1, $urandom_range(6, 0));
    wb(1'b0, `SCL_OFS_SUBVEN, 32'h0);
    chk(rd, 32'h0);
    rom_checks();
    wait_ready();
    chk(32'(rd[9]), 32'h1);
    wb(1'b0, `SCL_OFS_SUBVEN, 32'h0);
    chk(rd, {16'h0, eep.mem[1], eep.mem[0]});
    wb(1'b0, `SCL_OFS_SUBID, 32'h0);
    chk(rd, {16'h0, eep.mem[3], eep.mem[2]});
    wb(1'b1, `SCL_OFS_SUBVEN, 32'h0000_1234);
    wb(1'b0, `SCL_OFS_SUBVEN, 32'h0);
    chk(rd, {16'h0, eep.mem[1], eep.mem[0]});
    wb(1'b0, 8'h20, 32'h0);
    chk(rd, 32'h0);
    // both straps low, nothing answers on the wire
    boot(2'b00, 1'b0, 7);
    wait_ready();
    chk(32'(rd[8]), 32'h1);
    chk(32'(rd[9]), 32'h0);
    rom_checks();
    wb(1'b0, `SCL_OFS_SUBVEN, 32'h0);
    chk(rd, 32'h0);
    // software-driven pins
    boot(2'b10, 1'b0, $urandom_range(6, 0));
    wait_ready();
    wb(1'b0, `SCL_OFS_SUBID, 32'h0);
    chk(rd, 32'h0);
    wr = 16'($urandom);
    wb(1'b1, `SCL_OFS_SUBID, {16'h0, wr});
    wb(1'b0, `SCL_OFS_SUBID, 32'h0);
    chk(rd, {16'h0, wr});
    wb(1'b1, `SCL_OFS_PINCTL, 32'h13);
    repeat (4) @(posedge clock);
    chk({29'h0, flashPin, pin1Oe, pin0Oe}, 32'h7);
    wb(1'b0, `SCL_OFS_PINCTL, 32'h0);
    chk({30'h0, rd[9:8]}, 32'h0);
    wb(1'b1, `SCL_OFS_PINCTL, 32'h2);
    repeat (4) @(posedge clock);
    chk({29'h0, flashPin, pin1Oe, pin0Oe}, 32'h2);
    // both straps high, nothing answers; the reserved pair is never strapped
    boot(2'b11, 1'b0, $urandom_range(6, 0));
    wait_ready();
    chk(32'(rd[8]), 32'h1);
    chk({28'h0, pin1Out, pin0Out, pin1Oe, pin0Oe}, 32'h0);
    wb(1'b1, `SCL_OFS_SUBVEN, 32'h0000_5a5a);
    wb(1'b0, `SCL_OFS_SUBVEN, 32'h0);
    chk(rd, 32'h0);
    tally_and_finish();
  end
endmodule : tb_top
